/* File: srb_board.sv */
// Board model: fundamental reset pulse and strap levels
module srb_board #(
   parameter int HOLD = 8
) (
   input wire logic clk,
   input wire logic go,
   input wire srb_pkg::srb_straps_type cfg,
   output logic perst_n = 1'b0,
   output srb_pkg::srb_straps_type straps = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   // Straps move only while reset is low, then stay put
   always @(posedge clk) begin
      if (go) begin
         perst_n <= 1'b0;
         straps <= cfg;
         n <= HOLD;
      end else if (n > 0) begin
         n <= n - 1;
         perst_n <= (n == 1);
      end
   end
endmodule

/* File: srb_pkg.sv */
// Package: constants and types for the switch reset and boot-config block
package srb_pkg;
   localparam int unsigned CLK_HZ = 250000000;
   localparam int unsigned SMB_SLOW_HZ = 100000;
   localparam int unsigned SMB_FAST_HZ = 400000;
   // Half period of master bus clock in core cycles
   localparam int unsigned SMB_SLOW_HALF = CLK_HZ / (2 * SMB_SLOW_HZ);
   localparam int unsigned SMB_FAST_HALF = CLK_HZ / (2 * SMB_FAST_HZ);
   localparam int unsigned DIV_W = 11;
   // Reset procedure length in cycles
   localparam int unsigned RESET_PROC_CYCLES = 16;
   localparam int unsigned RST_CNT_W = 5;

   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_EEPROM = 3'h1;

   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_STRAPS = 8'h08;
   localparam int unsigned CTRL_HALT_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_PROC = 2'b01,
      ST_HALT = 2'b11,
      ST_RUN = 2'b10
   } srb_state_type;

   typedef struct packed {
      logic halt;
      logic [2:0] mode;
      logic smb_slow;
      logic cclk_ds;
      logic cclk_us;
      logic [3:0] eeprom_addr;
   } srb_straps_type;
endpackage

/* File: srb_smb_clkgen.sv */
// Master bus half-period enable divider
module srb_smb_clkgen
   import srb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic slow,
   output logic tick
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] lim;
   assign lim = slow ? DIV_W'(SMB_SLOW_HALF - 1) : DIV_W'(SMB_FAST_HALF - 1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (!run || cnt_q >= lim) begin
         cnt_q <= '0;
         tick <= run;
      end else begin
         cnt_q <= cnt_q + DIV_W'(1);
         tick <= 1'b0;
      end
   end
endmodule

/* File: srb_strap_sync.sv */
// Two-stage synchronizer for strap inputs
module srb_strap_sync #(
   parameter int unsigned W = 11
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: srb_top.sv */
// Reset sequencer, strap capture and control registers of the switch
// Operation
// - Asserting the fundamental reset clears all internal logic and starts a switch reset; here the AXI4-Lite channels are reset only by RST_N.
// - A halt strap seen during reset holds the switch in reset after the procedure, buses live.
// - Only a management master clearing the halt bit releases the halted state.
// - Mode code 0 is normal, 1 is normal with EEPROM load, 2 and above reserved.
// - The master management bus runs at 100 KHz when slow is strapped, else 400 KHz.
// - Software cannot override the master bus speed.
// - A set downstream common-clock strap marks a shared downstream reference clock.
// - A set upstream common-clock strap marks a shared upstream reference clock.
// - In EEPROM mode the EEPROM bus address comes from its address straps.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
module srb_top
   import srb_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic FUNDAMENTAL_RESET_N,
   input wire logic RESET_HALT_STRAP,
   input wire logic [2:0] SWITCH_MODE_SELECT,
   input wire logic MASTER_SMBUS_SLOW_SELECT,
   input wire logic COMMON_CLOCK_DOWNSTREAM,
   input wire logic COMMON_CLOCK_UPSTREAM,
   input wire logic [3:0] EEPROM_BUS_ADDRESS,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic SWITCH_RESET_N,
   output logic SMBUS_ACTIVE,
   output logic SMB_MASTER_TICK,
   output logic EEPROM_INIT_REQ,
   output logic [3:0] EEPROM_ADDR,
   output logic MODE_RESERVED,
   output logic CCLK_DS_OUT,
   output logic CCLK_US_OUT
);
   import srb_pkg::*;

   localparam int unsigned SW = $bits(srb_straps_type);

   srb_straps_type raw, synced, straps_q;
   srb_state_type state_q;
   logic perst_meta_q, perst_q;
   logic [RST_CNT_W-1:0] cnt_q;
   logic halt_q;
   logic tick;
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wr_fire;

   function automatic logic reg_mapped(input logic [7:0] a);
      reg_mapped = (a == ADDR_CONTROL) || (a == ADDR_STATUS) || (a == ADDR_STRAPS);
   endfunction

   assign raw = '{halt: RESET_HALT_STRAP, mode: SWITCH_MODE_SELECT,
                  smb_slow: MASTER_SMBUS_SLOW_SELECT, cclk_ds: COMMON_CLOCK_DOWNSTREAM,
                  cclk_us: COMMON_CLOCK_UPSTREAM, eeprom_addr: EEPROM_BUS_ADDRESS};

   srb_strap_sync #(.W(SW)) u_sync (
      .clk(CLOCK),
      .rst_n(RST_N),
      .d(raw),
      .q(synced)
   );

   // Reset input synchronized; outputs kept quiet on a glitch free path
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         perst_meta_q <= 1'b0;
         perst_q <= 1'b0;
      end else begin
         perst_meta_q <= FUNDAMENTAL_RESET_N;
         perst_q <= perst_meta_q;
      end
   end

   // Straps latched while reset held, frozen afterwards
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         straps_q <= '0;
      end else if (!perst_q) begin
         straps_q <= synced;
      end
   end

   // Reset sequencer
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_RESET;
         cnt_q <= '0;
      end else if (!perst_q) begin
         state_q <= ST_RESET;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_RESET: begin
               state_q <= ST_PROC;
               cnt_q <= '0;
            end
            ST_PROC: begin
               if (cnt_q == RST_CNT_W'(RESET_PROC_CYCLES - 1)) begin
                  state_q <= halt_q ? ST_HALT : ST_RUN;
               end
               cnt_q <= cnt_q + RST_CNT_W'(1);
            end
            ST_HALT: begin
               if (!halt_q) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: state_q <= ST_RUN;
            default: state_q <= ST_RESET;
         endcase
      end
   end

   // Halt bit: set from strap during reset, cleared only by a bus write
   assign wr_fire = aw_hold_q && w_hold_q && !BVALID;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         halt_q <= 1'b0;
      end else if (!perst_q) begin
         halt_q <= synced.halt;
      end else if (wr_fire && awaddr_q == ADDR_CONTROL && wdata_q[CTRL_HALT_BIT] == 1'b0) begin
         halt_q <= 1'b0;
      end
   end

   srb_smb_clkgen u_clk (
      .clk(CLOCK),
      .rst_n(RST_N),
      .run(perst_q),
      .slow(straps_q.smb_slow),
      .tick(tick)
   );

   // Status outputs
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         SWITCH_RESET_N <= 1'b0;
         SMBUS_ACTIVE <= 1'b0;
         SMB_MASTER_TICK <= 1'b0;
         EEPROM_INIT_REQ <= 1'b0;
         EEPROM_ADDR <= '0;
         MODE_RESERVED <= 1'b0;
         CCLK_DS_OUT <= 1'b0;
         CCLK_US_OUT <= 1'b0;
      end else begin
         SWITCH_RESET_N <= (state_q == ST_RUN) && perst_q;
         SMBUS_ACTIVE <= (state_q == ST_HALT || state_q == ST_RUN) && perst_q;
         SMB_MASTER_TICK <= tick;
         EEPROM_INIT_REQ <= (straps_q.mode == MODE_EEPROM) && perst_q;
         EEPROM_ADDR <= straps_q.eeprom_addr;
         MODE_RESERVED <= (straps_q.mode != MODE_NORMAL) && (straps_q.mode != MODE_EEPROM);
         CCLK_DS_OUT <= straps_q.cclk_ds;
         CCLK_US_OUT <= straps_q.cclk_us;
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
      end else begin
         AWREADY <= !aw_hold_q && !(AWVALID && AWREADY) && !BVALID;
         WREADY <= !w_hold_q && !(WVALID && WREADY) && !BVALID;
         if (AWVALID && AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q <= WDATA;
         end
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= RESP_OKAY;
      end else begin
         ARREADY <= !RVALID && !(ARVALID && ARREADY);
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= reg_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (ARADDR)
               ADDR_CONTROL: RDATA <= {31'h0, halt_q};
               ADDR_STATUS: RDATA <= {29'h0, perst_q, state_q}; // Speed is read-only
               ADDR_STRAPS: RDATA <= {21'h0, straps_q};
               default: RDATA <= 32'h0;
            endcase
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // A new fundamental reset may legally pull the halted state back to reset
   a_halt_holds: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_q == ST_HALT && halt_q && perst_q) |=> state_q == ST_HALT)
      else $error("halt state left while halt bit set");
   a_run_exit: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_q == ST_HALT && !halt_q && perst_q) |=> state_q == ST_RUN)
      else $error("halt not released after clear");
   a_reset_entry: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !perst_q |=> state_q == ST_RESET ##1 !SWITCH_RESET_N)
      else $error("fundamental reset not honoured");
   a_halt_path: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_q == ST_PROC && cnt_q == RST_CNT_W'(RESET_PROC_CYCLES - 1) && halt_q && perst_q)
      |=> state_q == ST_HALT)
      else $error("halt strap ignored");
   a_mode_decode: assert property (@(posedge CLOCK) disable iff (!RST_N)
      MODE_RESERVED |-> !EEPROM_INIT_REQ)
      else $error("reserved mode started eeprom load");
   a_straps_frozen: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ($past(perst_q) && perst_q) |-> $stable(straps_q))
      else $error("straps changed outside reset");
   a_eeprom_addr: assert property (@(posedge CLOCK) disable iff (!RST_N)
      1'b1 |=> EEPROM_ADDR == $past(straps_q.eeprom_addr))
      else $error("eeprom address mismatch");
   a_ccl_flags: assert property (@(posedge CLOCK) disable iff (!RST_N)
      1'b1 |=> (CCLK_DS_OUT == $past(straps_q.cclk_ds))
      && (CCLK_US_OUT == $past(straps_q.cclk_us)))
      else $error("common clock flag mismatch");
endmodule

/* File: srb_top_bench.sv */
// Self-checking bench for the reset and strap block
module srb_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import srb_pkg::*;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic go = 1'b0;
   srb_straps_type cfg = '0;
   srb_straps_type st;
   logic pn;
   logic [7:0] AWADDR = '0, ARADDR = '0;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic [31:0] WDATA = '0, RDATA, rdat;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SWITCH_RESET_N, SMBUS_ACTIVE;
   logic SMB_MASTER_TICK, EEPROM_INIT_REQ, MODE_RESERVED, CCLK_DS_OUT, CCLK_US_OUT;
   logic [1:0] BRESP, RRESP, rsp;
   logic [3:0] EEPROM_ADDR;
   int num_errors = 0, n_compared = 0, g;
   // Straps beside expected {init, addr, reserved, ds, us}
   logic [18:0] rows [4] = '{{11'h045, 8'h28}, {11'h0AA, 8'hD2}, {11'h15F, 8'h7D},
      {11'h3B0, 8'h07}};

   srb_board #(.HOLD(8)) far (.clk(CLOCK), .go, .cfg, .perst_n(pn), .straps(st));
   srb_top dut (.CLOCK, .RST_N, .FUNDAMENTAL_RESET_N(pn), .RESET_HALT_STRAP(st.halt),
      .SWITCH_MODE_SELECT(st.mode), .MASTER_SMBUS_SLOW_SELECT(st.smb_slow),
      .COMMON_CLOCK_DOWNSTREAM(st.cclk_ds), .COMMON_CLOCK_UPSTREAM(st.cclk_us),
      .EEPROM_BUS_ADDRESS(st.eeprom_addr), .AWADDR, .AWVALID, .AWREADY, .WDATA,
      .WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
      .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SWITCH_RESET_N, .SMBUS_ACTIVE,
      .SMB_MASTER_TICK, .EEPROM_INIT_REQ, .EEPROM_ADDR, .MODE_RESERVED, .CCLK_DS_OUT,
      .CCLK_US_OUT);

   always #2 CLOCK = ~CLOCK;

   task automatic bad(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) bad($sformatf("got %h want %h", got, exp));
   endtask
   task automatic stop_test;
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tmo;
      bad("timeout");
      stop_test;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask
   // Both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) break;
      end
      if (i == 50) tmo;
      rsp = BRESP;
      BREADY <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int i;
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
         if (RVALID) break;
      end
      if (i == 50) tmo;
      rdat = RDATA;
      rsp = RRESP;
      RREADY <= 1'b0;
      @(posedge CLOCK);
   endtask
   // Pulse the board reset, then expect the switch back in reset
   task automatic boot(input logic [10:0] c);
      cfg <= c;
      go <= 1'b1;
      @(posedge CLOCK);
      go <= 1'b0;
      cyc(6);
      chk(SWITCH_RESET_N, 0);
   endtask
   task automatic up(input int n);
      int i;
      for (i = 0; i < n && SWITCH_RESET_N !== 1'b1; i++) @(posedge CLOCK);
      if (i == n) tmo;
   endtask
   // Cycles from one bus tick to the next
   task automatic gap;
      int i;
      for (i = 0; i < 3000 && SMB_MASTER_TICK !== 1'b1; i++) @(posedge CLOCK);
      if (i == 3000) tmo;
      @(posedge CLOCK);
      for (g = 1; g < 3000 && SMB_MASTER_TICK !== 1'b1; g++) @(posedge CLOCK);
   endtask

   initial begin
      cyc(16);
      chk({SWITCH_RESET_N, SMBUS_ACTIVE, BVALID, RVALID, EEPROM_INIT_REQ}, 0);
      RST_N <= 1'b1;
      foreach (rows[k]) begin
         boot(rows[k][18:8]);
         up(100);
         chk(SMBUS_ACTIVE, 1);
         chk({EEPROM_INIT_REQ, EEPROM_ADDR}, rows[k][7:3]);
         chk(MODE_RESERVED, rows[k][2]);
         chk({CCLK_DS_OUT, CCLK_US_OUT}, rows[k][1:0]);
         rd_reg(ADDR_STRAPS);
         chk(rdat, rows[k][18:8]);
         // Software try at the speed must not stick
         wr(ADDR_STRAPS, 32'hFFFFFFFF);
         gap;
         chk(g, rows[k][14] ? SMB_SLOW_HALF : SMB_FAST_HALF);
      end
      boot(11'h400);
      cyc(60);
      chk({SWITCH_RESET_N, SMBUS_ACTIVE}, 2'b01);
      rd_reg(ADDR_STATUS);
      chk(rdat, 32'h7);
      wr(ADDR_CONTROL, 32'h1);
      cyc(10);
      chk(SWITCH_RESET_N, 0);
      wr(ADDR_CONTROL, 32'h0);
      up(20);
      rd_reg(ADDR_STATUS);
      chk(rdat, 32'h6);
      rd_reg(8'h0C);
      chk(rsp, RESP_SLVERR);
      chk(rdat, 0);
      wr(8'h0C, 32'h1);
      chk(rsp, RESP_SLVERR);
      // Second reset lands inside the procedure
      boot(11'h045);
      cyc(10);
      boot(11'h0AA);
      up(100);
      chk({EEPROM_INIT_REQ, EEPROM_ADDR}, 5'h1A);
      stop_test;
   end
endmodule
